// File: src/fot_params.svh
// offsets, reset values and timing counts for the follower offset trim block
`ifndef FOT_PARAMS_SVH
`define FOT_PARAMS_SVH

// clock rate
`define FOT_CLK_HZ 64'd125_000_000

// speed gate time in microseconds
`define FOT_GATE_US 32'd1000
`define FOT_GATE_CYC (`FOT_GATE_US * 32'd125)

// register byte offsets
`define FOT_OFS_ALLOC 8'h00
`define FOT_OFS_ENG 8'h04
`define FOT_OFS_MAX_FB 8'h08
`define FOT_OFS_PPR_FB 8'h0c
`define FOT_OFS_MAX_LEAD 8'h10
`define FOT_OFS_PPR_LEAD 8'h14
`define FOT_OFS_NULL 8'h18
`define FOT_OFS_AUTH 8'h1c
`define FOT_OFS_POL 8'h20
`define FOT_OFS_SETPT 8'h24
`define FOT_OFS_MONITOR 8'h28
`define FOT_OFS_RPM_LEAD 8'h2c
`define FOT_OFS_RPM_FB 8'h30
`define FOT_OFS_REF 8'h34
`define FOT_OFS_OFFSET 8'h38

// reset values (eng units and setpoint in thousandths, percents in tenths)
`define FOT_RST_ALLOC 8'h00
`define FOT_RST_ENG 16'h03e8
`define FOT_RST_MAX_FB 16'h07d0
`define FOT_RST_PPR_FB 16'h003c
`define FOT_RST_MAX_LEAD 16'h07d0
`define FOT_RST_PPR_LEAD 16'h003c
`define FOT_RST_NULL 16'h0000
`define FOT_RST_AUTH 16'h03e8
`define FOT_RST_POL 2'h1
`define FOT_RST_SETPT 16'h03e8

// codes
`define FOT_ALLOC_OFFSET 8'h03
`define FOT_POL_SUB 2'h2
`define FOT_RESP_OK 2'h0
`define FOT_RESP_ERR 2'h2

// full scale of percent (tenths) and of authority product
`define FOT_PCT_FULL 64'd1000
`define FOT_AUTH_DIV 64'd1_000_000

`endif

// File: src/fot_pkg.sv
// types for the follower offset trim block
package fot_pkg;

  // axi4-lite request bundle from the master
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fot_axi_req_t;

  // axi4-lite answer bundle from the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fot_axi_rsp_t;

  // operator configuration
  typedef struct packed {
    logic [7:0] analog_input_allocation;
    logic [15:0] follower_eng_units;
    logic [15:0] max_speed_feedback;
    logic [15:0] pulses_per_rev_feedback;
    logic [15:0] max_speed_lead;
    logic [15:0] pulses_per_rev_lead;
    logic [15:0] offset_null_point;
    logic [15:0] offset_authority_pct;
    logic [1:0] offset_polarity_sel;
    logic [15:0] follower_setpoint;
  } fot_cfg_t;

  // whole state of the block
  typedef struct packed {
    fot_cfg_t cfg;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] sync_lead;
    logic [2:0] sync_fb;
    logic lvl_lead;
    logic lvl_fb;
    logic [31:0] gate_cnt;
    logic [23:0] cnt_lead;
    logic [23:0] cnt_fb;
    logic [23:0] lat_lead;
    logic [23:0] lat_fb;
    logic [15:0] adc_code;
    logic [15:0] adjusted_analog_monitor;
    logic [31:0] rpm_lead;
    logic [31:0] rpm_fb;
    logic [31:0] offset;
    logic [31:0] ref_rpm;
  } fot_state_t;

endpackage

// File: src/fot_trim.sv
// follower offset trim: speed reference with dancer offset, axi4-lite registers
`timescale 1ns/1ns
`default_nettype none
`include "fot_params.svh"

// Functional notes
// RULE1 - allocation value 3 selects offset operation, the analog input then feeds the offset.
// RULE2 - in offset operation the reference is the follower scaled reference plus the offset term; the code clamps a negative sum to zero.
// RULE3 - the offset term is exactly zero when the analog percent equals the null point.
// RULE4 - at full-range analog input the offset equals the authority percent of full-scale feedback.
// RULE5 - polarity 1 raises follower speed above the null point and lowers it below.
// RULE6 - polarity 2 lowers follower speed above the null point and raises it below.
// RULE7 - reset gives allocation 0, units 1.000, speeds 2000, resolutions 60, null 0, authority 100.0, polarity 1.
// RULE8 - the engineering-units value is the ratio shown with lead and feedback at maximum speed.
// RULE9 - feedback pulses become shaft speed through the feedback pulses per revolution.
// RULE10 - lead pulses become shaft speed through the lead pulses per revolution.
// RULE11 - maximum feedback speed is full scale for the reference and the offset authority.
// RULE12 - maximum lead speed is the lead full scale when scaling measured lead speed.
// RULE13 - the operator reads the adjusted analog monitor at dancer neutral and enters it as null.
// RULE14 - offset is authority times analog minus null over 100, on full-scale feedback, signed by polarity.
module fot_trim #(
  parameter int GATE_CYC = `FOT_GATE_CYC,
  parameter int ADC_W = 12
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire fot_pkg::fot_axi_req_t axi_req_in,
  output var fot_pkg::fot_axi_rsp_t axi_rsp_out,
  // speed sensor pins
  input wire logic lead_pulse_in,
  input wire logic fb_pulse_in,
  // digitised analog input, same clock
  input wire logic [ADC_W-1:0] adc_code_in,
  input wire logic adc_valid_in,
  // results
  output logic signed [31:0] follower_ref_out,
  output logic offset_mode_out
);
  import fot_pkg::*;

  // converter full scale and gate length, widened for the dividers
  localparam logic [15:0] ADC_FULL = 16'((1 << ADC_W) - 1);
  localparam logic [63:0] GATE64 = 64'(GATE_CYC);

  // whole block state lives in one register
  fot_state_t s_r;
  fot_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes straight from state
  // readies fall while a half is held or an answer stands, so one write
  // and one read at most are ever in flight
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign axi_rsp_out.awready = ~s_r.aw_got & ~s_r.bvalid;
  assign axi_rsp_out.wready = ~s_r.w_got & ~s_r.bvalid;
  assign axi_rsp_out.arready = ~s_r.rvalid;
  assign axi_rsp_out.bvalid = s_r.bvalid;
  assign axi_rsp_out.bresp = s_r.bresp;
  assign axi_rsp_out.rvalid = s_r.rvalid;
  assign axi_rsp_out.rdata = s_r.rdata;
  assign axi_rsp_out.rresp = s_r.rresp;
  assign aw_take = axi_req_in.awvalid & axi_rsp_out.awready;
  assign w_take = axi_req_in.wvalid & axi_rsp_out.wready;
  assign ar_take = axi_req_in.arvalid & axi_rsp_out.arready;

  // reference output comes from a flip-flop, mode output is a compare on the allocation register
  assign follower_ref_out = $signed(s_r.ref_rpm);
  assign offset_mode_out = (s_r.cfg.analog_input_allocation == `FOT_ALLOC_OFFSET); // RULE1

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for writes
  // lanes with a low strobe keep their old bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // zero divisors read as one, so a half-configured drive never divides by zero
  function automatic logic [63:0] nz(input logic [63:0] v);
    return (v == 64'h0000_0000_0000_0000) ? 64'h0000_0000_0000_0001 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    // scratch values, each given a value before use
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic hit;
    logic [31:0] rd;
    logic [1:0] rr;
    logic gate_end;
    logic [63:0] num;
    logic [63:0] den;
    logic signed [63:0] diff;
    logic signed [63:0] offs;
    logic signed [63:0] base;
    logic signed [63:0] sum;
    // defaults: the state holds unless changed below
    wa = s_r.awaddr;
    wd = s_r.wdata;
    ws = s_r.wstrb;
    hit = 1'b1;
    rd = 32'h0000_0000;
    rr = `FOT_RESP_OK;
    gate_end = 1'b0;
    num = 64'h0000_0000_0000_0000;
    den = 64'h0000_0000_0000_0001;
    diff = 64'sh0;
    offs = 64'sh0;
    base = 64'sh0;
    sum = 64'sh0;
    s_nxt = s_r;

    // write address and data in either order
    if (aw_take) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req_in.awaddr;
      wa = axi_req_in.awaddr;
    end
    if (w_take) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req_in.wdata;
      s_nxt.wstrb = axi_req_in.wstrb;
      wd = axi_req_in.wdata;
      ws = axi_req_in.wstrb;
    end
    if (s_r.bvalid & axi_req_in.bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // both halves present: commit the write, answer next cycle
    // a half that came alone waits in the state for its partner
    if (s_nxt.aw_got & s_nxt.w_got & ~s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      unique case ({wa[7:2], 2'b00})
        `FOT_OFS_ALLOC: begin
          s_nxt.cfg.analog_input_allocation =
            8'(merge(32'(s_r.cfg.analog_input_allocation), wd, ws));
        end
        `FOT_OFS_ENG: begin
          s_nxt.cfg.follower_eng_units = 16'(merge(32'(s_r.cfg.follower_eng_units), wd, ws));
        end
        `FOT_OFS_MAX_FB: begin
          s_nxt.cfg.max_speed_feedback = 16'(merge(32'(s_r.cfg.max_speed_feedback), wd, ws));
        end
        `FOT_OFS_PPR_FB: begin
          s_nxt.cfg.pulses_per_rev_feedback =
            16'(merge(32'(s_r.cfg.pulses_per_rev_feedback), wd, ws));
        end
        `FOT_OFS_MAX_LEAD: begin
          s_nxt.cfg.max_speed_lead = 16'(merge(32'(s_r.cfg.max_speed_lead), wd, ws));
        end
        `FOT_OFS_PPR_LEAD: begin
          s_nxt.cfg.pulses_per_rev_lead = 16'(merge(32'(s_r.cfg.pulses_per_rev_lead), wd, ws));
        end
        `FOT_OFS_NULL: begin
          s_nxt.cfg.offset_null_point = 16'(merge(32'(s_r.cfg.offset_null_point), wd, ws));
        end
        `FOT_OFS_AUTH: begin
          s_nxt.cfg.offset_authority_pct = 16'(merge(32'(s_r.cfg.offset_authority_pct), wd, ws));
        end
        `FOT_OFS_POL: begin
          s_nxt.cfg.offset_polarity_sel = 2'(merge(32'(s_r.cfg.offset_polarity_sel), wd, ws));
        end
        `FOT_OFS_SETPT: begin
          s_nxt.cfg.follower_setpoint = 16'(merge(32'(s_r.cfg.follower_setpoint), wd, ws));
        end
        default: begin
          hit = 1'b0; // read-only or unmapped: nothing stored
        end
      endcase
      s_nxt.bresp = hit ? `FOT_RESP_OK : `FOT_RESP_ERR;
    end

    // reads: one outstanding, answer in the next cycle
    if (s_r.rvalid & axi_req_in.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // arready is low while an answer stands, so rdata is never overwritten
    if (ar_take) begin
      unique case ({axi_req_in.araddr[7:2], 2'b00})
        `FOT_OFS_ALLOC: begin
          rd = 32'(s_r.cfg.analog_input_allocation);
        end
        `FOT_OFS_ENG: begin
          rd = 32'(s_r.cfg.follower_eng_units);
        end
        `FOT_OFS_MAX_FB: begin
          rd = 32'(s_r.cfg.max_speed_feedback);
        end
        `FOT_OFS_PPR_FB: begin
          rd = 32'(s_r.cfg.pulses_per_rev_feedback);
        end
        `FOT_OFS_MAX_LEAD: begin
          rd = 32'(s_r.cfg.max_speed_lead);
        end
        `FOT_OFS_PPR_LEAD: begin
          rd = 32'(s_r.cfg.pulses_per_rev_lead);
        end
        `FOT_OFS_NULL: begin
          rd = 32'(s_r.cfg.offset_null_point);
        end
        `FOT_OFS_AUTH: begin
          rd = 32'(s_r.cfg.offset_authority_pct);
        end
        `FOT_OFS_POL: begin
          rd = 32'(s_r.cfg.offset_polarity_sel);
        end
        `FOT_OFS_SETPT: begin
          rd = 32'(s_r.cfg.follower_setpoint);
        end
        `FOT_OFS_MONITOR: begin
          rd = 32'(s_r.adjusted_analog_monitor); // RULE13
        end
        `FOT_OFS_RPM_LEAD: begin
          rd = s_r.rpm_lead;
        end
        `FOT_OFS_RPM_FB: begin
          rd = s_r.rpm_fb;
        end
        `FOT_OFS_REF: begin
          rd = s_r.ref_rpm;
        end
        `FOT_OFS_OFFSET: begin
          rd = s_r.offset;
        end
        default: begin
          rr = `FOT_RESP_ERR; // unmapped: zero data, error code
        end
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rr;
    end

    // pin synchronisers: level moves only once stages two and three agree
    // pins are asynchronous to clk_in; the third stage hides a metastable second
    s_nxt.sync_lead = {s_r.sync_lead[1:0], lead_pulse_in};
    s_nxt.sync_fb = {s_r.sync_fb[1:0], fb_pulse_in};
    if (s_r.sync_lead[1] == s_r.sync_lead[2]) begin
      s_nxt.lvl_lead = s_r.sync_lead[2];
    end
    if (s_r.sync_fb[1] == s_r.sync_fb[2]) begin
      s_nxt.lvl_fb = s_r.sync_fb[2];
    end

    // pulse counting over a fixed gate
    // a level rise is one pulse; the count is frozen into lat_* at gate end
    gate_end = (s_r.gate_cnt >= 32'(GATE_CYC - 1));
    s_nxt.gate_cnt = gate_end ? 32'h0000_0000 : s_r.gate_cnt + 32'h0000_0001;
    if (s_nxt.lvl_lead & ~s_r.lvl_lead) begin
      s_nxt.cnt_lead = s_r.cnt_lead + 24'h00_0001;
    end
    if (s_nxt.lvl_fb & ~s_r.lvl_fb) begin
      s_nxt.cnt_fb = s_r.cnt_fb + 24'h00_0001;
    end
    if (gate_end) begin
      s_nxt.lat_lead = s_nxt.cnt_lead;
      s_nxt.lat_fb = s_nxt.cnt_fb;
      s_nxt.cnt_lead = 24'h00_0000;
      s_nxt.cnt_fb = 24'h00_0000;
    end

    // rpm = pulses * 60 * f_clk / (gate * ppr)
    // 64-bit products so a full 24-bit count cannot overflow
    num = 64'(s_r.lat_lead) * 64'd60 * `FOT_CLK_HZ;
    den = nz(GATE64 * 64'(s_r.cfg.pulses_per_rev_lead));
    s_nxt.rpm_lead = 32'(num / den); // RULE10
    num = 64'(s_r.lat_fb) * 64'd60 * `FOT_CLK_HZ;
    den = nz(GATE64 * 64'(s_r.cfg.pulses_per_rev_feedback));
    s_nxt.rpm_fb = 32'(num / den); // RULE9

    // analog level as tenths of a percent of full scale
    // between strobes the converter code is not trusted and never loaded
    if (adc_valid_in) begin
      s_nxt.adc_code = 16'(adc_code_in);
    end
    num = 64'(s_r.adc_code) * `FOT_PCT_FULL;
    s_nxt.adjusted_analog_monitor = 16'(num / nz(64'(ADC_FULL)));

    // scaled reference: (setpoint / units) * (lead / max lead) * max feedback
    // follows a register write or a new rpm one cycle later
    num = 64'(s_r.cfg.follower_setpoint) * 64'(s_r.rpm_lead)
        * 64'(s_r.cfg.max_speed_feedback); // RULE11
    den = nz(64'(s_r.cfg.follower_eng_units) * 64'(s_r.cfg.max_speed_lead)); // RULE8 RULE12
    base = $signed(num / den);

    // offset: authority * (analog - null) / 100 of full-scale feedback
    // division truncates toward zero, so a tiny deviation gives no trim
    diff = $signed(64'(s_r.adjusted_analog_monitor)) - $signed(64'(s_r.cfg.offset_null_point)); // RULE3
    offs = diff * $signed(64'(s_r.cfg.offset_authority_pct))
         * $signed(64'(s_r.cfg.max_speed_feedback)); // RULE4 RULE14
    offs = offs / $signed(`FOT_AUTH_DIV);
    if (s_r.cfg.offset_polarity_sel == `FOT_POL_SUB) begin
      offs = -offs; // RULE6
    end // polarity 1 keeps the sign: RULE5
    if (s_r.cfg.analog_input_allocation != `FOT_ALLOC_OFFSET) begin
      offs = 64'sh0; // RULE1
    end
    s_nxt.offset = 32'(offs);

    // motor never runs backwards on a large negative trim
    sum = base + offs; // RULE2
    s_nxt.ref_rpm = (sum < 0) ? 32'h0000_0000 : 32'(sum);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // reset loads the operator defaults, all else clears
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.cfg.analog_input_allocation <= `FOT_RST_ALLOC; // RULE7
      s_r.cfg.follower_eng_units <= `FOT_RST_ENG;
      s_r.cfg.max_speed_feedback <= `FOT_RST_MAX_FB;
      s_r.cfg.pulses_per_rev_feedback <= `FOT_RST_PPR_FB;
      s_r.cfg.max_speed_lead <= `FOT_RST_MAX_LEAD;
      s_r.cfg.pulses_per_rev_lead <= `FOT_RST_PPR_LEAD;
      s_r.cfg.offset_null_point <= `FOT_RST_NULL;
      s_r.cfg.offset_authority_pct <= `FOT_RST_AUTH;
      s_r.cfg.offset_polarity_sel <= `FOT_RST_POL;
      s_r.cfg.follower_setpoint <= `FOT_RST_SETPT;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// File: testbench/follower_offset_trim_test.sv
// self-checking bench for the follower offset trim block
`timescale 1ns/1ns
`default_nettype none
`include "fot_params.svh"
module follower_offset_trim_test;
  import fot_pkg::*;
  localparam int GATE = 3000;
  localparam logic [1:0] OK = `FOT_RESP_OK;
  localparam logic [1:0] ERR = `FOT_RESP_ERR;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  fot_axi_req_t req = '0;
  fot_axi_rsp_t rsp;
  logic [11:0] pot = 12'h0000;
  logic lead_p, fb_p, adc_v;
  logic [11:0] adc_c;
  logic signed [31:0] ref_o;
  logic mode_o;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic lazy = 1'b0;
  logic [31:0] dflt [10] = '{32'h0, 32'h0000_03e8, 32'h0000_07d0, 32'h0000_003c,
    32'h0000_07d0, 32'h0000_003c, 32'h0, 32'h0000_03e8, 32'h0000_0001, 32'h0000_03e8};
  logic [11:0] codes [6] = '{12'h0999, 12'h0fff, 12'h0000, 12'h0ccc, 12'h0fff, 12'h0000};
  logic [1:0] pols [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [31:0] offs [6] = '{32'h0, 32'h0000_006c, 32'hffff_ff5e, 32'h0000_0036,
    32'hffff_ff94, 32'h0000_00a2};
  always #4 clk_in = ~clk_in;
  fot_sensor_model model (.clk_in(clk_in), .rst_n_in(rst_n_in), .pot_code_in(pot),
    .lead_pulse_out(lead_p), .fb_pulse_out(fb_p), .adc_code_out(adc_c), .adc_valid_out(adc_v));
  fot_trim #(.GATE_CYC(GATE), .ADC_W(12)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .lead_pulse_in(lead_p), .fb_pulse_in(fb_p),
    .adc_code_in(adc_c), .adc_valid_in(adc_v), .follower_ref_out(ref_o),
    .offset_mode_out(mode_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // halves offered together, each dropped at the edge it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_in);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= !lazy;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_in);
      aw_ok = aw_ok || rsp.awready;
      w_ok = w_ok || rsp.wready;
      @(posedge clk_in);
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
    end
    do @(negedge clk_in); while (!rsp.bvalid);
    // a late bready leaves the answer standing for a cycle
    if (lazy) begin
      @(posedge clk_in);
      req.bready <= 1'b1;
      @(negedge clk_in);
    end
    chk(32'(rsp.bresp), 32'(er));
    @(posedge clk_in);
    req.bready <= 1'b0;
  endtask
  // ready sampled at the falling edge is what the next rising edge sees
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
    output logic [31:0] d);
    @(posedge clk_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= !lazy;
    do @(negedge clk_in); while (!rsp.arready);
    @(posedge clk_in);
    req.arvalid <= 1'b0;
    do @(negedge clk_in); while (!rsp.rvalid);
    // a late rready leaves the answer standing for a cycle
    if (lazy) begin
      @(posedge clk_in);
      req.rready <= 1'b1;
      @(negedge clk_in);
    end
    d = rsp.rdata;
    chk(rsp.rdata, ed);
    chk(32'(rsp.rresp), 32'(er));
    @(posedge clk_in);
    req.rready <= 1'b0;
  endtask
  // converter strobe plus two pipeline stages fits well inside 8 cycles
  task automatic ref_chk(input logic [31:0] exp);
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk(ref_o, exp);
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (dflt[i]) rd_chk(8'(i * 4), dflt[i], OK, rd);
    chk(32'(mode_o), 32'h0);
    rd_chk(8'h3c, 32'h0, ERR, rd);
    wr(8'h34, 32'h0000_0001, ERR);
    lazy = 1'b1;
    rd_chk(8'h08, 32'h0000_07d0, OK, rd);
    wr(8'h24, 32'h0000_03e8, OK);
    lazy = 1'b0;
    $display("test defaults done");
    // gates settle with 60 lead and 30 feedback pulses each
    repeat (3 * GATE) @(posedge clk_in);
    rd_chk(8'h2c, 32'h0026_25a0, OK, rd);
    rd_chk(8'h30, 32'h0013_12d0, OK, rd);
    chk(ref_o, 32'h0026_25a0);
    wr(8'h04, 32'h0000_07d0, OK);
    ref_chk(32'h0013_12d0);
    wr(8'h04, 32'h0000_03e8, OK);
    wr(8'h10, 32'h0000_04e2, OK);
    ref_chk(32'h003d_0900);
    wr(8'h08, 32'h0000_03e8, OK);
    ref_chk(32'h001e_8480);
    wr(8'h0c, 32'h0000_001e, OK);
    repeat (3 * GATE) @(posedge clk_in);
    rd_chk(8'h30, 32'h0026_25a0, OK, rd);
    $display("test scaling done");
    wr(8'h08, 32'h0000_0708, OK);
    wr(8'h10, 32'h0000_0708, OK);
    wr(8'h00, 32'h0000_0003, OK);
    chk(32'(mode_o), 32'h1);
    @(posedge clk_in);
    pot <= 12'h0999;
    repeat (8) @(posedge clk_in);
    rd_chk(8'h28, 32'h0000_0258, OK, rd);
    wr(8'h18, rd, OK);
    wr(8'h1c, 32'h0000_0096, OK);
    // dancer sweep over null, full, zero and 80 percent codes in polarity 1, full and zero codes in polarity 2
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      pot <= codes[i];
      wr(8'h20, 32'(pols[i]), OK);
      ref_chk(32'h0026_25a0 + offs[i]);
      rd_chk(8'h38, offs[i], OK, rd);
    end
    $display("test offset done");
    wr(8'h00, 32'h0, OK);
    ref_chk(32'h0026_25a0);
    chk(32'(mode_o), 32'h0);
    $display("test mode off done");
    close_out();
  end
endmodule
`default_nettype wire

// File: testbench/fot_sensor_model.sv
// shaft sensors and dancer pot converter model
`timescale 1ns/1ns
`default_nettype none
module fot_sensor_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pot position from the bench
  input wire logic [11:0] pot_code_in,
  // sensor and converter outputs
  output logic lead_pulse_out,
  output logic fb_pulse_out,
  output logic [11:0] adc_code_out,
  output logic adc_valid_out
);
  int cyc;
  // one shaft counter: lead every 50 cycles, feedback every 100, so any gate
  // that is a multiple of 100 cycles sees an exact pulse count
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc <= 0;
    end else begin
      cyc <= (cyc == 99) ? 0 : cyc + 1;
    end
  end
  assign lead_pulse_out = (cyc % 50) < 25;
  assign fb_pulse_out = cyc < 50;
  // converter strobes every fourth cycle; code is garbage between strobes
  assign adc_valid_out = (cyc % 4) == 0;
  assign adc_code_out = adc_valid_out ? pot_code_in : ~pot_code_in;
endmodule
`default_nettype wire

// File: testbench/fot_trim_monitor.sv
// port checker for the follower offset trim block
`timescale 1ns/1ns
`default_nettype none
module fot_trim_monitor #(
  parameter int GATE_CYC = 125000,
  parameter int ADC_W = 12
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire fot_pkg::fot_axi_req_t axi_req_in,
  input wire fot_pkg::fot_axi_rsp_t axi_rsp_out,
  // sensors and converter
  input wire logic lead_pulse_in,
  input wire logic fb_pulse_in,
  input wire logic [ADC_W-1:0] adc_code_in,
  input wire logic adc_valid_in,
  // results
  input wire logic signed [31:0] follower_ref_out,
  input wire logic offset_mode_out
);
  import fot_pkg::*;
  logic wr_both;
  // both write halves taken on one edge
  assign wr_both = axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid
    && axi_rsp_out.wready;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  mode_write_a: assert property (
    wr_both && axi_req_in.awaddr[7:2] == 6'h00 && axi_req_in.wstrb[0] |=>
    offset_mode_out == ($past(axi_req_in.wdata[7:0]) == 8'h03)) else $error("mode bit wrong");
  mode_change_a: assert property (
    $changed(offset_mode_out) |-> $rose(axi_rsp_out.bvalid)) else $error("mode moved alone");
  reset_dflt_a: assert property (
    !$past(rst_n_in) |-> !offset_mode_out && follower_ref_out == 32'h0)
    else $error("reset state wrong");
  ref_clamp_a: assert property (
    !follower_ref_out[31]) else $error("reference negative");
  ro_refuse_a: assert property (
    wr_both && axi_req_in.awaddr[7:2] inside {[6'h0a:6'h0e]} |=>
    axi_rsp_out.bvalid && axi_rsp_out.bresp == 2'h2) else $error("result register written");
  bresp_hold_a: assert property (
    axi_rsp_out.bvalid && !axi_req_in.bready |=> axi_rsp_out.bvalid
    && $stable(axi_rsp_out.bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (
    axi_rsp_out.rvalid && !axi_req_in.rready |=> axi_rsp_out.rvalid
    && $stable(axi_rsp_out.rdata)) else $error("read answer dropped");
  rd_answer_a: assert property (
    axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid)
    else $error("read answer late");
endmodule
bind fot_trim fot_trim_monitor #(.GATE_CYC(GATE_CYC), .ADC_W(ADC_W)) mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
  .lead_pulse_in(lead_pulse_in), .fb_pulse_in(fb_pulse_in), .adc_code_in(adc_code_in),
  .adc_valid_in(adc_valid_in), .follower_ref_out(follower_ref_out),
  .offset_mode_out(offset_mode_out));
`default_nettype wire
